// ===== rtl/fccu_pkg.sv
// Function
// - only Read ID, recalibrate, seek and the reset poll interrupt
// - Read ID fails after two index pulses
// - recalibrate steps outward until track zero
// - 79 steps without track zero: error
// - busy in command and result phases, not in execution
// - seek direction follows cylinder comparison
// - steps spaced by interval, compare after each
// - leaving power-down clears cylinders and status
// - interrupt on Read ID result and positioning end
// - sense interrupt clears and reports cause
// - drive stays busy until sense interrupt
// - sense drive status goes straight to result
// - specify sets unload, step, load times
// - first step spacing may be shorter
// - transfer mode must select DMA
// - configure defaults apply without command
// - auto seek before read or write
// - queue disabled means byte requests
// - one polling interrupt after reset
// - threshold code 00 one, 0F sixteen
// - precomp start track 0 to 255
// - version byte; relative seek encoding
// - relative direction 0 out, 1 in
// - relative step past track zero: error
package fccu_pkg;
  // register byte offsets
  localparam logic [7:0] FCCU_ADR_CMD = 8'h00;    // command byte in, write
  localparam logic [7:0] FCCU_ADR_RES = 8'h04;    // result byte out, read
  localparam logic [7:0] FCCU_ADR_STAT = 8'h08;   // main status, read
  localparam logic [7:0] FCCU_ADR_DRV = 8'h0C;    // drive select / power control
  localparam logic [7:0] FCCU_ADR_CFG = 8'h10;    // configure options, read
  localparam logic [7:0] FCCU_ADR_RATE = 8'h14;   // data rate select
  // command opcodes, low five bits of first byte
  localparam logic [4:0] FCCU_OP_SPECIFY = 5'h03;
  localparam logic [4:0] FCCU_OP_SDRV = 5'h04;
  localparam logic [4:0] FCCU_OP_RECAL = 5'h07;
  localparam logic [4:0] FCCU_OP_SINT = 5'h08;
  localparam logic [4:0] FCCU_OP_READID = 5'h0A;
  localparam logic [4:0] FCCU_OP_SEEK = 5'h0F;
  localparam logic [4:0] FCCU_OP_VERSION = 5'h10;
  localparam logic [4:0] FCCU_OP_CONFIG = 5'h13;
  localparam logic [7:0] FCCU_VERSION_BYTE = 8'h5A; // arbitrary identity value
  // interrupt codes and status bit positions
  localparam logic [1:0] FCCU_IC_NORMAL = 2'h0;
  localparam logic [1:0] FCCU_IC_ABNORMAL = 2'h1;
  localparam logic [1:0] FCCU_IC_INVALID = 2'h2;
  localparam logic [1:0] FCCU_IC_POLL = 2'h3;
  localparam int FCCU_ST0_SE = 5;
  localparam int FCCU_ST0_EC = 4;
  localparam int FCCU_ST1_MA = 0;
  localparam logic [7:0] FCCU_RECAL_MAX = 8'h4F;  // 79 steps
  localparam logic [7:0] FCCU_CFG_DEFAULT = 8'h20; // queue off, poll on, thr 0
  // timing
  localparam int FCCU_CLK_MHZ = 100;
  localparam int FCCU_STEP_UNIT_US = 500;  // one step code unit at rate 1; rate 0, the fastest, uses half
  localparam int FCCU_PULSE_US = 1;        // step pulse width
  localparam int FCCU_UNIT_CYC = FCCU_STEP_UNIT_US * FCCU_CLK_MHZ / 2;
  localparam int FCCU_PULSE_CYC = FCCU_PULSE_US * FCCU_CLK_MHZ;
  localparam int FCCU_NDRV = 4;
endpackage

// ===== rtl/fccu_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fccu_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1_r;  // first stage, read only by second
    logic s2_r;
  } fccu_sync_t;
  fccu_sync_t st_r, st_nxt;
  // shift one stage per clock
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1_r = d;
    st_nxt.s2_r = st_r.s1_r;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2_r;
endmodule
`default_nettype wire

// ===== rtl/fccu_stepper.sv
`timescale 1ns/1ps
`default_nettype none
module fccu_stepper
  import fccu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,          // begin a step, one cycle
  input wire logic [21:0] gap_cyc, // spacing after the pulse
  output logic step_out,           // step pulse to drive
  output logic done                // one cycle when interval ends
);
  typedef struct packed {
    logic busy_r;
    logic [21:0] cnt_r;
    logic pulse_r;
    logic done_r;
  } fccu_step_t;
  fccu_step_t st_r, st_nxt;
  // pulse, then wait the interval
  always_comb begin
    st_nxt = st_r;
    st_nxt.done_r = 1'b0;
    if (!st_r.busy_r) begin
      if (start) begin
        st_nxt.busy_r = 1'b1;
        st_nxt.pulse_r = 1'b1;
        st_nxt.cnt_r = 22'(FCCU_PULSE_CYC - 1);
      end
    end else if (st_r.cnt_r != 22'h000000) begin
      st_nxt.cnt_r = st_r.cnt_r - 22'h000001;
    end else if (st_r.pulse_r) begin
      st_nxt.pulse_r = 1'b0;
      st_nxt.cnt_r = gap_cyc;
    end else begin
      st_nxt.busy_r = 1'b0;
      st_nxt.done_r = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign step_out = st_r.pulse_r;
  assign done = st_r.done_r;
endmodule
`default_nettype wire

// ===== rtl/fccu_top.sv
`timescale 1ns/1ps
`default_nettype none
module fccu_top
  import fccu_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic TRACK_ZERO_IN,   // high at track zero
  input wire logic INDEX_PULSE_IN,  // high on index
  input wire logic ID_FOUND_IN,     // data path found an ID field
  input wire logic [31:0] ID_FIELD_IN,
  output logic STEP_OUT,
  output logic DIR_OUT,
  output logic [1:0] DRIVE_SEL_OUT,
  output logic INT_OUT,
  output logic BYTE_MODE_OUT,       // transfers requested byte by byte
  output logic [3:0] QUEUE_THR_OUT,
  output logic [7:0] PRECOMP_START_TRACK_OUT,
  output logic AUTO_SEEK_OUT
);
  import fccu_pkg::*;
  typedef enum {S_IDLE, S_PARAM, S_EXEC, S_RESULT} fccu_phase_t;
  typedef enum {P_NONE, P_SEEK, P_RECAL, P_RSEEK} fccu_pos_t;
  typedef struct packed {
    fccu_phase_t phase_r;
    logic [4:0] op_r;
    logic rel_r;               // relative seek marker
    logic rdir_r;              // relative step direction
    logic [2:0] nbyte_r;       // parameter bytes left
    logic [2:0] pidx_r;
    logic [7:0] p0_r;          // drive / head byte
    logic [7:0] p1_r;
    logic [7:0] p2_r;
    logic [7:0] p3_r;
    logic [55:0] res_r;        // result bytes, first in low byte
    logic [2:0] nres_r;
    fccu_pos_t pos_r;
    logic [1:0] pdrv_r;
    logic [7:0] present_cylinder_r;
    logic [7:0] target_cylinder_r;
    logic [7:0] relative_step_count_r;
    logic [7:0] nsteps_r;
    logic step_go_r;
    logic step_wait_r;
    logic first_step_r;
    logic dir_r;
    logic [3:0] drv_busy_r;    // per-drive positioning pending
    logic int_r;
    logic [7:0] status_zero_r;
    logic [7:0] st1_r;
    logic [1:0] idx_seen_r;
    logic idx_prev_r;
    logic [3:0] step_interval_setting_r;
    logic [3:0] head_unload_delay_r;
    logic [6:0] head_load_delay_r;
    logic transfer_mode_select_r;
    logic auto_seek_option_r;
    logic queue_disable_option_r;
    logic poll_disable_r;
    logic [3:0] queue_threshold_r;
    logic [7:0] precomp_start_track_r;
    logic poll_done_r;
    logic head_loaded_r;
    logic pdown_r;
    logic [1:0] rate_r;
    logic ack_r;
    logic [31:0] dat_r;
  } fccu_state_t;
  fccu_state_t st_r, st_nxt;
  logic trk0_s; // synchronised track zero
  logic idx_s;  // synchronised index
  logic idf_s;  // synchronised ID found
  logic step_done;
  logic [21:0] gap_cyc;
  fccu_sync u_trk (.clk(REF_CLK), .rst(RST), .d(TRACK_ZERO_IN), .q(trk0_s));
  fccu_sync u_idx (.clk(REF_CLK), .rst(RST), .d(INDEX_PULSE_IN), .q(idx_s));
  fccu_sync u_idf (.clk(REF_CLK), .rst(RST), .d(ID_FOUND_IN), .q(idf_s));
  // parameter bytes per opcode
  function automatic logic [2:0] param_count(input logic [4:0] op);
    unique case (op)
      FCCU_OP_SPECIFY: param_count = 3'h2;
      FCCU_OP_SDRV, FCCU_OP_RECAL, FCCU_OP_READID: param_count = 3'h1;
      FCCU_OP_SEEK: param_count = 3'h2;
      FCCU_OP_CONFIG: param_count = 3'h3;
      default: param_count = 3'h0;
    endcase
  endfunction
  // step interval in units, scaled by rate
  always_comb begin
    logic [4:0] units;
    units = 5'h10 - {1'b0, st_r.step_interval_setting_r};
    gap_cyc = 22'(FCCU_UNIT_CYC) * 22'(units) << st_r.rate_r;
    if (st_r.first_step_r) begin
      gap_cyc = gap_cyc >> 1;
    end
  end
  fccu_stepper u_step (
    .clk(REF_CLK), .rst(RST), .start(st_r.step_go_r), .gap_cyc(gap_cyc),
    .step_out(STEP_OUT), .done(step_done)
  );
  logic bus_req;
  assign bus_req = CYC_I && STB_I && !st_r.ack_r;
  // whole controller next-state
  always_comb begin
    logic wr;
    logic rd_res;
    logic [7:0] b;
    logic pos_end;
    wr = bus_req && WE_I && SEL_I[0];
    rd_res = bus_req && !WE_I && (ADR_I == FCCU_ADR_RES);
    b = DAT_I[7:0];
    pos_end = 1'b0;
    st_nxt = st_r;
    st_nxt.ack_r = bus_req;
    st_nxt.step_go_r = 1'b0;
    st_nxt.idx_prev_r = idx_s;
    // bus reads
    if (bus_req && !WE_I) begin
      unique case (ADR_I)
        FCCU_ADR_RES: st_nxt.dat_r = {24'h000000, st_r.res_r[7:0]};
        // busy only in command and result phases
        FCCU_ADR_STAT: st_nxt.dat_r = {24'h0, st_r.int_r, st_r.pdown_r,
          st_r.phase_r == S_RESULT, st_r.phase_r != S_IDLE && st_r.phase_r != S_EXEC,
          st_r.drv_busy_r};
        FCCU_ADR_DRV: st_nxt.dat_r = {29'h0, st_r.pdown_r, st_r.pdrv_r};
        FCCU_ADR_CFG: st_nxt.dat_r = {16'h0, st_r.precomp_start_track_r,
          st_r.auto_seek_option_r, st_r.queue_disable_option_r,
          st_r.poll_disable_r, 1'b0, st_r.queue_threshold_r};
        FCCU_ADR_RATE: st_nxt.dat_r = {30'h0, st_r.rate_r};
        default: st_nxt.dat_r = 32'h00000000;
      endcase
    end
    // result byte popped by each read
    if (rd_res && st_r.phase_r == S_RESULT) begin
      st_nxt.res_r = st_r.res_r >> 8;
      st_nxt.nres_r = st_r.nres_r - 3'h1;
      if (st_r.nres_r == 3'h1) begin
        st_nxt.phase_r = S_IDLE;
      end
    end
    // register writes
    if (wr && ADR_I == FCCU_ADR_RATE) begin
      st_nxt.rate_r = b[1:0];
    end
    if (wr && ADR_I == FCCU_ADR_DRV) begin
      st_nxt.pdown_r = b[2];
      if (st_r.pdown_r && !b[2]) begin
        // leaving power-down wipes position and status
        st_nxt.present_cylinder_r = 8'h00;
        st_nxt.status_zero_r = 8'h00;
        st_nxt.st1_r = 8'h00;
        st_nxt.int_r = 1'b0;
        st_nxt.drv_busy_r = 4'h0;
      end
    end
    // one polling interrupt after reset
    if (!st_r.poll_done_r && !st_r.poll_disable_r && !st_r.head_loaded_r) begin
      st_nxt.poll_done_r = 1'b1;
      st_nxt.int_r = 1'b1;
      st_nxt.status_zero_r = {FCCU_IC_POLL, 6'h00};
    end
    // command phase
    if (wr && ADR_I == FCCU_ADR_CMD) begin
      if (st_r.phase_r == S_IDLE) begin
        st_nxt.op_r = b[4:0];
        st_nxt.rel_r = b[7];
        st_nxt.rdir_r = b[6];
        st_nxt.pidx_r = 3'h0;
        st_nxt.nbyte_r = param_count(b[4:0]);
        st_nxt.phase_r = (param_count(b[4:0]) == 3'h0) ? S_EXEC : S_PARAM;
      end else if (st_r.phase_r == S_PARAM) begin
        unique case (st_r.pidx_r)
          3'h0: st_nxt.p0_r = b;
          3'h1: st_nxt.p1_r = b;
          default: st_nxt.p2_r = b;
        endcase
        st_nxt.pidx_r = st_r.pidx_r + 3'h1;
        st_nxt.nbyte_r = st_r.nbyte_r - 3'h1;
        if (st_r.nbyte_r == 3'h1) begin
          st_nxt.phase_r = S_EXEC;
        end
      end
    end
    // execution of the latched command
    if (st_r.phase_r == S_EXEC) begin
      st_nxt.phase_r = S_IDLE;
      unique case (st_r.op_r)
        FCCU_OP_SPECIFY: begin
          st_nxt.step_interval_setting_r = st_r.p0_r[7:4];
          st_nxt.head_unload_delay_r = st_r.p0_r[3:0];
          st_nxt.head_load_delay_r = st_r.p1_r[7:1];
          st_nxt.transfer_mode_select_r = st_r.p1_r[0];
        end
        FCCU_OP_CONFIG: begin
          st_nxt.auto_seek_option_r = st_r.p1_r[6];
          st_nxt.queue_disable_option_r = st_r.p1_r[5];
          st_nxt.poll_disable_r = st_r.p1_r[4];
          st_nxt.queue_threshold_r = st_r.p1_r[3:0];
          st_nxt.precomp_start_track_r = st_r.p2_r;
        end
        FCCU_OP_SDRV: begin
          // straight to result
          st_nxt.res_r = {48'h0, 2'b00, 1'b0, trk0_s, 1'b0, st_r.p0_r[2:0]};
          st_nxt.nres_r = 3'h1;
          st_nxt.phase_r = S_RESULT;
        end
        FCCU_OP_VERSION: begin
          st_nxt.res_r = {48'h0, FCCU_VERSION_BYTE};
          st_nxt.nres_r = 3'h1;
          st_nxt.phase_r = S_RESULT;
        end
        FCCU_OP_SINT: begin
          // clear int, report cause, head bit 0
          st_nxt.res_r = {40'h0, st_r.present_cylinder_r,
            st_r.int_r ? {st_r.status_zero_r[7:3], 3'b000} : 8'h80};
          st_nxt.nres_r = 3'h2;
          st_nxt.phase_r = S_RESULT;
          st_nxt.int_r = 1'b0;
          st_nxt.drv_busy_r = 4'h0;
        end
        FCCU_OP_READID: begin
          st_nxt.idx_seen_r = 2'h0;
          st_nxt.pdrv_r = st_r.p0_r[1:0];
          st_nxt.phase_r = S_EXEC;
          st_nxt.op_r = 5'h1F;   // internal search state
        end
        5'h1F: begin
          st_nxt.phase_r = S_EXEC;
          if (idf_s) begin
            // first readable ID latched
            st_nxt.res_r = {ID_FIELD_IN, 8'h00, 8'h00, {FCCU_IC_NORMAL, 3'b000,
              1'b0, st_r.pdrv_r}};
            st_nxt.nres_r = 3'h7;
            st_nxt.phase_r = S_RESULT;
            st_nxt.int_r = 1'b1;
          end else if (st_r.idx_seen_r == 2'h2) begin
            st_nxt.st1_r[FCCU_ST1_MA] = 1'b1;
            st_nxt.res_r = {32'h0, 8'h00, 8'h01, {FCCU_IC_ABNORMAL, 6'h00}};
            st_nxt.nres_r = 3'h7;
            st_nxt.phase_r = S_RESULT;
            st_nxt.int_r = 1'b1;
          end else if (idx_s && !st_r.idx_prev_r) begin
            st_nxt.idx_seen_r = st_r.idx_seen_r + 2'h1;
          end
        end
        FCCU_OP_RECAL, FCCU_OP_SEEK: begin
          // positioning runs in background
          st_nxt.pdrv_r = st_r.p0_r[1:0];
          st_nxt.drv_busy_r[st_r.p0_r[1:0]] = 1'b1;
          st_nxt.first_step_r = 1'b1;
          st_nxt.nsteps_r = 8'h00;
          if (st_r.op_r == FCCU_OP_RECAL) begin
            st_nxt.pos_r = P_RECAL;
            st_nxt.present_cylinder_r = 8'h00;
            st_nxt.dir_r = 1'b0;
          end else if (st_r.rel_r) begin
            st_nxt.pos_r = P_RSEEK;
            st_nxt.relative_step_count_r = st_r.p1_r;
            st_nxt.dir_r = st_r.rdir_r;
          end else begin
            st_nxt.pos_r = P_SEEK;
            st_nxt.target_cylinder_r = st_r.p1_r;
            st_nxt.dir_r = st_r.present_cylinder_r < st_r.p1_r;
          end
        end
        default: begin
          st_nxt.res_r = {48'h0, FCCU_IC_INVALID, 6'h00};
          st_nxt.nres_r = 3'h1;
          st_nxt.phase_r = S_RESULT;
        end
      endcase
    end
    // positioning engine
    if (st_r.pos_r != P_NONE && !st_r.step_wait_r && !st_r.step_go_r) begin
      if (st_r.pos_r == P_RECAL && trk0_s) begin
        pos_end = 1'b1;
        st_nxt.status_zero_r = {FCCU_IC_NORMAL, 6'h20} | {6'h0, st_r.pdrv_r};
      end else if (st_r.pos_r == P_RECAL && st_r.nsteps_r == FCCU_RECAL_MAX) begin
        pos_end = 1'b1;
        st_nxt.status_zero_r = {FCCU_IC_ABNORMAL, 6'h30} | {6'h0, st_r.pdrv_r};
      end else if (st_r.pos_r == P_SEEK &&
                   st_r.present_cylinder_r == st_r.target_cylinder_r) begin
        pos_end = 1'b1;
        st_nxt.status_zero_r = {FCCU_IC_NORMAL, 6'h20} | {6'h0, st_r.pdrv_r};
      end else if (st_r.pos_r == P_RSEEK && st_r.relative_step_count_r == 8'h00) begin
        pos_end = 1'b1;
        st_nxt.status_zero_r = {FCCU_IC_NORMAL, 6'h20} | {6'h0, st_r.pdrv_r};
      end else if (st_r.pos_r == P_RSEEK && !st_r.dir_r && trk0_s) begin
        pos_end = 1'b1;  // outward past track zero
        st_nxt.status_zero_r = {FCCU_IC_ABNORMAL, 6'h30} | {6'h0, st_r.pdrv_r};
      end else begin
        st_nxt.step_go_r = 1'b1;
        st_nxt.step_wait_r = 1'b1;
      end
    end
    if (step_done) begin
      // count the step, compare next cycle
      st_nxt.step_wait_r = 1'b0;
      st_nxt.first_step_r = 1'b0;
      st_nxt.nsteps_r = st_r.nsteps_r + 8'h01;
      if (st_r.pos_r == P_RSEEK) begin
        st_nxt.relative_step_count_r = st_r.relative_step_count_r - 8'h01;
      end
      if (st_r.pos_r != P_RECAL) begin
        st_nxt.present_cylinder_r = st_r.dir_r ? st_r.present_cylinder_r + 8'h01
                                               : st_r.present_cylinder_r - 8'h01;
      end
    end
    if (pos_end) begin
      st_nxt.pos_r = P_NONE;
      st_nxt.int_r = 1'b1;
    end
  end
  // whole-state register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
      st_r.queue_disable_option_r <= 1'b1;
      st_r.pos_r <= P_NONE;
      st_r.phase_r <= S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign DAT_O = st_r.dat_r;
  assign ACK_O = st_r.ack_r;
  assign DIR_OUT = st_r.dir_r;
  assign DRIVE_SEL_OUT = st_r.pdrv_r;
  assign INT_OUT = st_r.int_r;
  assign BYTE_MODE_OUT = st_r.queue_disable_option_r;
  assign QUEUE_THR_OUT = st_r.queue_threshold_r;
  assign PRECOMP_START_TRACK_OUT = st_r.precomp_start_track_r;
  assign AUTO_SEEK_OUT = st_r.auto_seek_option_r;
endmodule
`default_nettype wire

// ===== bench/fccu_props.sv
`timescale 1ns/1ps
`default_nettype none
module fccu_props
  import fccu_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic STEP_OUT,
  input wire logic DIR_OUT,
  input wire logic INT_OUT,
  input wire logic BYTE_MODE_OUT,
  input wire logic [3:0] QUEUE_THR_OUT,
  input wire logic [7:0] PRECOMP_START_TRACK_OUT,
  input wire logic AUTO_SEEK_OUT
);
  // helper state for step checks
  typedef struct packed {
    logic [7:0] hi_cnt;   // cycles high
    logic [19:0] gap_cnt; // cycles since last rise
    logic seen;           // a step was seen
    logic step_d;         // step level one cycle ago
  } fccu_chk_t;
  fccu_chk_t s_r;
  fccu_chk_t s_nxt;
  // gap saturates, so idle never wraps to a short gap
  always_comb begin
    s_nxt = s_r;
    s_nxt.step_d = STEP_OUT;
    s_nxt.hi_cnt = STEP_OUT ? s_r.hi_cnt + 8'h01 : 8'h00;
    if (STEP_OUT && !s_r.step_d) begin
      s_nxt.gap_cnt = 20'h00000;
      s_nxt.seen = 1'b1;
    end else if (s_r.gap_cnt != 20'hFFFFF) begin
      s_nxt.gap_cnt = s_r.gap_cnt + 20'h00001;
    end
  end
  // register helper state
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack late");
  chk_ack_drop: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  chk_poll_int: assert property ($fell(RST) |-> ##[0:4] INT_OUT)
    else $error("no poll interrupt");
  chk_cfg_default: assert property ($fell(RST) |-> BYTE_MODE_OUT && !AUTO_SEEK_OUT
    && QUEUE_THR_OUT == 4'h0 && PRECOMP_START_TRACK_OUT == 8'h00)
    else $error("options not default");
  chk_busy_exec: assert property (
    ACK_O && !WE_I && ADR_I == FCCU_ADR_STAT && STEP_OUT |-> !DAT_O[4])
    else $error("busy while stepping");
  chk_step_width: assert property ($fell(STEP_OUT) |-> s_r.hi_cnt == 8'(FCCU_PULSE_CYC))
    else $error("step width");
  chk_step_gap: assert property (
    STEP_OUT && !s_r.step_d && s_r.seen |-> s_r.gap_cnt >= 20'(FCCU_UNIT_CYC / 2))
    else $error("steps too close");
  chk_dir_stable: assert property (STEP_OUT && $past(STEP_OUT) |-> $stable(DIR_OUT))
    else $error("dir moved in pulse");
  chk_int_clear: assert property (
    $fell(INT_OUT) |-> $past(CYC_I, 1) || $past(CYC_I, 2) || $past(CYC_I, 3))
    else $error("int dropped unasked");
endmodule
bind fccu_top fccu_props u_props (.REF_CLK(REF_CLK), .RST(RST), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT), .INT_OUT(INT_OUT), .BYTE_MODE_OUT(BYTE_MODE_OUT),
  .QUEUE_THR_OUT(QUEUE_THR_OUT), .PRECOMP_START_TRACK_OUT(PRECOMP_START_TRACK_OUT),
  .AUTO_SEEK_OUT(AUTO_SEEK_OUT));
`default_nettype wire

// ===== bench/fccu_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fccu_drive_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic step_out,
  input wire logic dir_out,
  output logic track_zero_in,
  output logic index_pulse_in,
  output logic id_found_in,
  output logic [31:0] id_field_in
);
  // blank disk: no ID field is ever found
  typedef struct packed {
    logic [7:0] pos;   // physical head track
    logic [11:0] turn; // place in a short revolution
    logic step_d;      // step level one cycle ago
  } fccu_drv_t;
  fccu_drv_t s_r;
  fccu_drv_t s_nxt;
  // head moves on each rising step, stops at track zero
  always_comb begin
    s_nxt = s_r;
    s_nxt.step_d = step_out;
    s_nxt.turn = s_r.turn + 12'h001;
    if (step_out && !s_r.step_d) begin
      if (dir_out) begin
        s_nxt.pos = s_r.pos + 8'h01;
      end else if (s_r.pos != 8'h00) begin
        s_nxt.pos = s_r.pos - 8'h01;
      end
    end
  end
  // register state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign track_zero_in = (s_r.pos == 8'h00);
  assign index_pulse_in = (s_r.turn < 12'h010);
  assign id_found_in = 1'b0;
  // never valid: a moving pattern
  assign id_field_in = {20'hA5C3E, s_r.turn};
endmodule
`default_nettype wire

// ===== bench/fccu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fccu_top_tb;
  import fccu_pkg::*;
  logic clk, rst, cyc, stb, we, ack, step, dir, int_o, trk0, idx, idf, byte_mode, aseek;
  logic [7:0] adr, pre;
  logic [3:0] thr;
  logic [1:0] dsel;
  logic [31:0] wdat, rdat, idfield;
  logic [7:0] res [8]; // last result bytes
  int nres, fail_count, checks_done, steps_in, steps_out;
  fccu_top u_dut (.REF_CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'h1), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .TRACK_ZERO_IN(trk0),
    .INDEX_PULSE_IN(idx), .ID_FOUND_IN(idf), .ID_FIELD_IN(idfield), .STEP_OUT(step),
    .DIR_OUT(dir), .DRIVE_SEL_OUT(dsel), .INT_OUT(int_o), .BYTE_MODE_OUT(byte_mode),
    .QUEUE_THR_OUT(thr), .PRECOMP_START_TRACK_OUT(pre), .AUTO_SEEK_OUT(aseek));
  fccu_drive_model u_drive (.clk(clk), .rst(rst), .step_out(step), .dir_out(dir),
    .track_zero_in(trk0), .index_pulse_in(idx), .id_found_in(idf), .id_field_in(idfield));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // steps by direction
  always @(posedge step) begin
    if (dir) begin
      steps_in++;
    end else begin
      steps_out++;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // classic cycle held until ack, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    d = q[7:0];
  endtask
  // read result bytes while ready
  task automatic get_res();
    logic [7:0] s;
    nres = 0;
    foreach (res[i]) res[i] = 8'hEE;
    rd(FCCU_ADR_STAT, s);
    while (s[5] === 1'b1 && nres < 8) begin
      rd(FCCU_ADR_RES, res[nres]);
      nres++;
      rd(FCCU_ADR_STAT, s);
    end
  endtask
  task automatic sint();
    wr(FCCU_ADR_CMD, {3'h0, FCCU_OP_SINT});
    get_res();
  endtask
  task automatic wait_int();
    logic [7:0] s;
    int n;
    n = 0;
    while (int_o !== 1'b1 && n < 20000) begin
      rd(FCCU_ADR_STAT, s);
      n++;
    end
    check("int", {31'h0, int_o}, 32'h1);
  endtask
  task automatic t_poll();
    check("byte mode", {31'h0, byte_mode}, 32'h1);
    check("thr", {28'h0, thr}, 32'h0);
    check("precomp", {24'h0, pre}, 32'h0);
    check("aseek", {31'h0, aseek}, 32'h0);
    check("poll int", {31'h0, int_o}, 32'h1);
    sint();
    check("poll cause", {24'h0, res[0] & 8'hE4}, 32'hC0);
    check("int clear", {31'h0, int_o}, 32'h0);
  endtask
  // short commands; none interrupts
  task automatic t_short();
    logic [31:0] q;
    logic [7:0] s;
    wr(FCCU_ADR_CMD, {3'h0, FCCU_OP_VERSION});
    get_res();
    check("version", {24'h0, res[0]}, {24'h0, FCCU_VERSION_BYTE});
    check("ver bytes", nres, 1);
    bus(1'b0, 8'h20, 32'h00000000, q);
    check("unmapped", q, 32'h0);
    wr(FCCU_ADR_CMD, {3'h0, FCCU_OP_SDRV});
    wr(FCCU_ADR_CMD, 8'h00);
    rd(FCCU_ADR_STAT, s);
    check("sdrv ready", {31'h0, s[5]}, 32'h1);
    get_res();
    check("sdrv bytes", nres, 1);
    // fastest step, shortest load, DMA
    wr(FCCU_ADR_CMD, {3'h0, FCCU_OP_SPECIFY});
    wr(FCCU_ADR_CMD, 8'hF0);
    wr(FCCU_ADR_CMD, 8'h02);
    check("no int", {31'h0, int_o}, 32'h0);
  endtask
  // options to a corner and back
  task automatic t_cfg();
    logic [7:0] opt [2] = '{8'h4F, 8'h20};
    logic [7:0] trk [2] = '{8'hFF, 8'h00};
    for (int i = 0; i < 2; i++) begin
      wr(FCCU_ADR_CMD, {3'h0, FCCU_OP_CONFIG});
      wr(FCCU_ADR_CMD, 8'h00);
      wr(FCCU_ADR_CMD, opt[i]);
      wr(FCCU_ADR_CMD, trk[i]);
      check("aseek", {31'h0, aseek}, {31'h0, opt[i][6]});
      check("byte mode", {31'h0, byte_mode}, {31'h0, opt[i][5]});
      check("thr", {28'h0, thr}, {28'h0, opt[i][3:0]});
      check("precomp", {24'h0, pre}, {24'h0, trk[i]});
    end
    check("no int", {31'h0, int_o}, 32'h0);
  endtask
  // positioning; negative expectations skipped
  task automatic posn(input logic [7:0] op, input logic [7:0] cnt, input int din,
      input int dout, input logic [7:0] m0, input logic [7:0] e0, input int cyl);
    logic [7:0] s;
    int si, so;
    si = steps_in;
    so = steps_out;
    wr(FCCU_ADR_CMD, op);
    wr(FCCU_ADR_CMD, 8'h00);
    if (op[4:0] != FCCU_OP_RECAL) wr(FCCU_ADR_CMD, cnt);
    rd(FCCU_ADR_STAT, s);
    check("exec busy", {30'h0, s[4], s[0]}, 32'h1);
    wait_int();
    if (din >= 0) check("steps in", steps_in - si, din);
    if (dout >= 0) check("steps out", steps_out - so, dout);
    rd(FCCU_ADR_STAT, s);
    check("held busy", {31'h0, s[0]}, 32'h1);
    sint();
    check("st0", {24'h0, res[0] & m0}, {24'h0, e0});
    if (cyl >= 0) check("cyl", {24'h0, res[1]}, cyl);
    rd(FCCU_ADR_STAT, s);
    check("freed", {31'h0, s[0]}, 32'h0);
  endtask
  // blank disk: read id gives up
  task automatic t_readid();
    wr(FCCU_ADR_CMD, {3'h0, FCCU_OP_READID});
    wr(FCCU_ADR_CMD, 8'h01);
    wait_int();
    check("drive sel", {30'h0, dsel}, 32'h1);
    get_res();
    check("id bytes", nres, 7);
    check("id code", {24'h0, res[0] & 8'hC0}, 32'h40);
    check("missing mark", {24'h0, res[1] & 8'h01}, 32'h1);
  endtask
  initial begin
    fail_count = 0;
    checks_done = 0;
    steps_in = 0;
    steps_out = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_poll();
    t_short();
    t_cfg();
    posn(8'h0F, 8'h01, 1, 0, 8'hF4, 8'h20, 1);
    posn(8'h07, 8'h00, 0, 1, 8'hF4, 8'h20, 0);
    posn(8'hCF, 8'h01, 1, 0, 8'hF4, 8'h20, 1);
    // power-down forgets the cylinder; head is on track one
    wr(FCCU_ADR_DRV, 8'h04);
    wr(FCCU_ADR_DRV, 8'h00);
    if (int_o === 1'b1) sint();
    posn(8'h8F, 8'h02, 0, 1, 8'h10, 8'h10, -1);
    t_readid();
    conclude();
  end
  // watchdog beyond the longest run
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
